// ### common/flar_consts.vh
// constants for the fault latch and auto-retry block
`ifndef FLAR_CONSTS_VH
`define FLAR_CONSTS_VH
`define FLAR_NCH 4
`define FLAR_RETRY_MAX 5'h10
`define FLAR_RETRY_NS 150000000
`define FLAR_RETRY_CYC (`FLAR_RETRY_NS / 10)
`define FLAR_STEP_NS 10000
`define FLAR_STEP_CYC (`FLAR_STEP_NS / 10)
`define FLAR_COOL_NS 1000000
`define FLAR_COOL_CYC (`FLAR_COOL_NS / 10)
`define FLAR_LVL_W 3
`define FLAR_LVL_HI1 3'h7
`define FLAR_LVL_HI2 3'h6
`define FLAR_LVL_HI3 3'h5
`define FLAR_LVL_MED 3'h4
`define FLAR_LVL_LO4 3'h3
`define FLAR_LVL_LO3 3'h2
`define FLAR_LVL_LO2 3'h1
`define FLAR_LVL_LO1 3'h0
`define FLAR_ST_IDLE 2'h0
`define FLAR_ST_ON 2'h1
`define FLAR_ST_LATCH 2'h2
`define FLAR_ST_WAIT 2'h3
`endif

// ### hdl/flar_channel.v
// one output channel: fault latch, retry timer and current level profile
`timescale 1ns/1ns
`include "flar_consts.vh"
module flar_channel #(
   parameter RETRY_CYC = `FLAR_RETRY_CYC,
   parameter STEP_CYC = `FLAR_STEP_CYC,
   parameter COOL_CYC = `FLAR_COOL_CYC
) (
   input wire clk,
   input wire rst_n,
   input wire turn_on_cmd,
   input wire ot_det,
   input wire oc_det,
   input wire sc_det,
   input wire uv_det,
   input wire uv_flag,
   input wire ot_flag,
   input wire oc_flag,
   input wire fault_mode,
   input wire mode_change,
   input wire supply_reset,
   input wire [1:0] overcurrent_slope_select,
   input wire inrush_step_remove,
   input wire [1:0] steady_level_select,
   input wire cooling_ok,
   input wire [1:0] cooling_slope_select,
   output reg output_switch,
   output reg latched,
   output reg [2:0] current_level,
   output reg [4:0] retry_count
);
   // state codes
   localparam ST_IDLE = `FLAR_ST_IDLE;
   localparam ST_ON = `FLAR_ST_ON;
   localparam ST_LATCH = `FLAR_ST_LATCH;
   localparam ST_WAIT = `FLAR_ST_WAIT;
   reg [1:0] state; // channel state
   reg [1:0] next_state; // next channel state
   reg cmd_q; // previous command, for edge detection
   reg sc_latched; // severe short latch, immune to retry
   reg [31:0] timer; // retry period counter
   reg [31:0] step_timer; // inrush step counter
   reg [31:0] off_timer; // cooling emulation off time
   reg [2:0] step; // current inrush step index
   reg from_retry; // on-time begun by a retry
   wire cmd_rise = turn_on_cmd & ~cmd_q;
   wire any_fault = ot_det | oc_det | sc_det | uv_det;
   // step length scales with the slope field: each code up doubles every step, up to eight times
   wire [31:0] step_len = STEP_CYC << (overcurrent_slope_select & {2{~from_retry}});
   wire [31:0] cool_len = COOL_CYC << cooling_slope_select;
   wire retry_done = (timer >= RETRY_CYC - 1);
   wire retry_req = oc_flag | ot_flag | uv_flag;
   wire retry_ok = fault_mode & retry_req & ~sc_latched & (retry_count < `FLAR_RETRY_MAX);
   // next state
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (turn_on_cmd & ~any_fault)
               next_state = ST_ON;
         end
         ST_ON: begin
            // RULE_01 latch on fault
            if (any_fault)
               next_state = ST_LATCH;
            else if (!turn_on_cmd)
               next_state = ST_IDLE;
         end
         ST_LATCH: begin
            // RULE_02 release on condition clear
            if (!any_fault & retry_ok)
               next_state = ST_WAIT;
            // RULE_24 toggle when no retry is allowed: exhausted, short latched or no flag
            else if (!any_fault & cmd_rise)
               next_state = ST_ON;
            else if (!turn_on_cmd & !any_fault & ~sc_latched & ~retry_ok)
               next_state = ST_LATCH;
         end
         ST_WAIT: begin
            // RULE_20 retry after one period
            if (any_fault)
               next_state = ST_LATCH;
            else if (retry_done)
               next_state = turn_on_cmd ? ST_ON : ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
      // RULE_18 supply reset clears latch
      if (supply_reset | mode_change)
         next_state = ST_IDLE;
   end
   // state, timers and retry counter
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         cmd_q <= 1'b0;
         sc_latched <= 1'b0;
         timer <= 32'h0;
         retry_count <= 5'h0;
         off_timer <= 32'h0;
         from_retry <= 1'b0;
      end else begin
         state <= next_state;
         cmd_q <= turn_on_cmd;
         // RULE_22 retry runs on defaults
         from_retry <= (state == ST_WAIT) | (from_retry & (state == ST_ON));
         // RULE_10 short latch ignores retry
         if (supply_reset | mode_change | (cmd_rise & ~sc_det))
            sc_latched <= 1'b0;
         else if (sc_det & state == ST_ON)
            sc_latched <= 1'b1;
         timer <= (state == ST_WAIT) ? timer + 32'h1 : 32'h0;
         // RULE_21 counters clear on mode change
         if (mode_change | supply_reset)
            retry_count <= 5'h0;
         else if (state == ST_WAIT && next_state != ST_WAIT && !any_fault)
            retry_count <= retry_count + 5'h1;
         else if (cmd_rise & state != ST_WAIT)
            retry_count <= 5'h0;
         // off time feeds the cooling emulator
         if (output_switch)
            off_timer <= 32'h0;
         else if (off_timer != 32'hffffffff)
            off_timer <= off_timer + 32'h1;
      end
   end
   // RULE_05 inrush restarts on rise or retry
   // RULE_22 retry reverts to default profile
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         step <= 3'h0;
         step_timer <= 32'h0;
      end else if (state != ST_ON) begin
         step <= 3'h0;
         step_timer <= 32'h0;
      end else if (step != 3'h4) begin
         if (step_timer >= step_len - 1) begin
            step <= step + 3'h1;
            step_timer <= 32'h0;
         end else begin
            step_timer <= step_timer + 32'h1;
         end
      end
   end
   // level table; RULE_06 step removal, RULE_07 steady level, RULE_09 cooling
   always @* begin
      case (step)
         3'h0: begin
            if (inrush_step_remove & ~from_retry)
               current_level = `FLAR_LVL_HI2;
            else if (cooling_ok & ~from_retry & off_timer < cool_len)
               current_level = `FLAR_LVL_HI3;
            else
               current_level = `FLAR_LVL_HI1;
         end
         3'h1: current_level = `FLAR_LVL_HI2;
         3'h2: current_level = `FLAR_LVL_HI3;
         3'h3: current_level = `FLAR_LVL_MED;
         default: begin
            case (steady_level_select & {2{~from_retry}})
               2'h0: current_level = `FLAR_LVL_LO2;
               2'h1: current_level = `FLAR_LVL_LO1;
               2'h2: current_level = `FLAR_LVL_LO3;
               default: current_level = `FLAR_LVL_LO4;
            endcase
         end
      endcase
   end
   // output drive and latch indication
   always @* begin
      output_switch = (state == ST_ON);
      latched = (state == ST_LATCH) | (state == ST_WAIT) | sc_latched;
   end
endmodule // flar_channel

// ### hdl/flar_top.v
// four channel protection fault logic with status register and auto-retry
// How it works
// RULE_01 - on-command overtemp latches output off, pin low
// RULE_02 - latch releases after clear plus retry/toggle/reset
// RULE_03 - off-command overtemp drives pin low unlatched
// RULE_04 - overtemp flag sets, clears on read
// RULE_05 - inrush profile on command rise or retry
// RULE_06 - slope field and inrush step removal
// RULE_07 - steady level default second, selectable
// RULE_08 - overcurrent latches like overtemp, clears on read
// RULE_09 - cooling emulation shapes first step
// RULE_10 - short latches off, retry cannot release
// RULE_11 - short flags clear on read
// RULE_12 - overvoltage shuts all outputs while present
// RULE_13 - overvoltage flag sets, clears on read
// RULE_14 - disabled overvoltage only warns, sticky while present
// RULE_15 - fail-safe overvoltage follows wake/reset pin
// RULE_16 - undervoltage turns off, flag, keeps config
// RULE_17 - recovery: off releases pin, on stays latched
// RULE_18 - supply loss resets all latched faults
// RULE_19 - retry requested by overcurrent, overtemp, undervoltage
// RULE_20 - retry after one period, 16 maximum
// RULE_21 - retry counters clear on mode change
// RULE_22 - retry reverts overcurrent to defaults
// RULE_23 - turn-on command from direct input or bit
// RULE_24 - exhausted retries hold until toggle/reset
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "flar_consts.vh"
module flar_top #(
   parameter RETRY_CYC = `FLAR_RETRY_CYC,
   parameter COOL_CYC = `FLAR_COOL_CYC
) (
   input wire clk,
   input wire rst_n,
   input wire [3:0] reg_addr,
   input wire [31:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [31:0] reg_rdata,
   input wire [3:0] direct_in,
   input wire [3:0] overtemp_det,
   input wire [3:0] overcurrent_det,
   input wire [3:0] short_det,
   input wire overvoltage_det,
   input wire undervoltage_det,
   input wire logic_supply_fail,
   input wire supply_por,
   input wire fail_safe,
   input wire wake_reset_pin,
   input wire modulator_en,
   output wire [3:0] output_switch,
   output wire fault_status_pin_n,
   output wire [11:0] current_level
);
   // register map
   localparam [3:0] A_CTRL = 4'h0;
   localparam [3:0] A_OC = 4'h1;
   localparam [3:0] A_STAT = 4'h2;
   localparam [3:0] A_RETRY = 4'h3;
   // software configuration
   reg [3:0] on_bit; // per output on bit
   reg [3:0] input_mask; // masks direct inputs
   reg high_battery_protect_off; // overvoltage shutdown disable
   reg [1:0] overcurrent_slope_select; // inrush slope
   reg inrush_step_remove; // omit first step
   reg [1:0] steady_level_select; // steady level
   reg cooling_emulation_enable; // cooling emulator on
   reg [1:0] cooling_slope_select; // emulator slope
   // sticky status
   reg [3:0] overtemp_flag;
   reg [3:0] overcurrent_flag;
   reg [3:0] short_circuit_flag;
   reg overvoltage_flag;
   reg undervoltage_flag;
   reg fail_safe_q; // previous mode, for change detection
   wire [3:0] ch_switch;
   wire [3:0] ch_latched;
   wire [19:0] ch_retry;
   wire [3:0] turn_on;
   wire mode_change = fail_safe ^ fail_safe_q;
   // RULE_18 logic or both supplies lost
   wire supply_reset = logic_supply_fail | supply_por;
   wire fault_mode = (|overtemp_det) | (|overcurrent_det) | (|short_det) | undervoltage_det | (|ch_latched);
   // RULE_15 fail-safe follows the pin
   wire ov_protect = fail_safe ? wake_reset_pin : ~high_battery_protect_off;
   // RULE_12 all outputs off during overvoltage
   wire ov_kill = ov_protect & overvoltage_det;
   // read of the status word clears the sticky flags it reported
   wire stat_rd = reg_rd & (reg_addr == A_STAT);
   // RULE_23 turn-on from input or bit
   assign turn_on = (direct_in & ~input_mask & {4{modulator_en}}) | on_bit;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_ch
         flar_channel #(
            .RETRY_CYC(RETRY_CYC),
            .STEP_CYC(`FLAR_STEP_CYC),
            .COOL_CYC(COOL_CYC)
         ) u_ch (
            .clk(clk),
            .rst_n(rst_n),
            .turn_on_cmd(turn_on[g]),
            .ot_det(overtemp_det[g]),
            .oc_det(overcurrent_det[g]),
            .sc_det(short_det[g]),
            .uv_det(undervoltage_det),
            // RULE_19 retry sources
            .uv_flag(undervoltage_flag),
            .ot_flag(overtemp_flag[g]),
            .oc_flag(overcurrent_flag[g]),
            .fault_mode(fault_mode),
            .mode_change(mode_change),
            .supply_reset(supply_reset),
            .overcurrent_slope_select(overcurrent_slope_select),
            .inrush_step_remove(inrush_step_remove),
            .steady_level_select(steady_level_select),
            .cooling_ok(cooling_emulation_enable & modulator_en & ~fail_safe),
            .cooling_slope_select(cooling_slope_select),
            .output_switch(ch_switch[g]),
            .latched(ch_latched[g]),
            .current_level(current_level[3*g +: 3]),
            .retry_count(ch_retry[5*g +: 5])
         );
      end
   endgenerate
   // RULE_16 outputs off on undervoltage
   assign output_switch = ch_switch & {4{~ov_kill & ~undervoltage_det}};
   // RULE_03 unlatched pin for off-command overtemp
   // RULE_17 latched channels hold pin low after recovery
   assign fault_status_pin_n = ~((|ch_latched) | (|(overtemp_det & ~turn_on)) | ov_kill | undervoltage_det);
   // configuration writes
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         on_bit <= 4'h0;
         input_mask <= 4'h0;
         high_battery_protect_off <= 1'b0;
         overcurrent_slope_select <= 2'h0;
         inrush_step_remove <= 1'b0;
         steady_level_select <= 2'h0;
         cooling_emulation_enable <= 1'b0;
         cooling_slope_select <= 2'h0;
         fail_safe_q <= 1'b0;
      end else begin
         fail_safe_q <= fail_safe;
         // configuration defaults on fail-safe, logic supply loss or power-on reset
         if (fail_safe | supply_reset) begin
            on_bit <= 4'h0;
            input_mask <= 4'h0;
            high_battery_protect_off <= 1'b0;
            overcurrent_slope_select <= 2'h0;
            inrush_step_remove <= 1'b0;
            steady_level_select <= 2'h0;
            cooling_emulation_enable <= 1'b0;
            cooling_slope_select <= 2'h0;
         end else if (reg_wr & reg_addr == A_CTRL) begin
            on_bit <= reg_wdata[3:0];
            input_mask <= reg_wdata[7:4];
            high_battery_protect_off <= reg_wdata[8];
         end else if (reg_wr & reg_addr == A_OC) begin
            overcurrent_slope_select <= reg_wdata[1:0];
            inrush_step_remove <= reg_wdata[2];
            steady_level_select <= reg_wdata[5:4];
            cooling_emulation_enable <= reg_wdata[6];
            cooling_slope_select <= reg_wdata[9:8];
         end
      end
   end
   // sticky flags: set wins over the read clear
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         overtemp_flag <= 4'h0;
         overcurrent_flag <= 4'h0;
         short_circuit_flag <= 4'h0;
         overvoltage_flag <= 1'b0;
         undervoltage_flag <= 1'b0;
      end else if (supply_por) begin
         overtemp_flag <= 4'h0;
         overcurrent_flag <= 4'h0;
         short_circuit_flag <= 4'h0;
         overvoltage_flag <= 1'b0;
         undervoltage_flag <= 1'b0;
      end else begin
         // RULE_04 overtemp sticky, read clears
         overtemp_flag <= overtemp_det | (overtemp_flag & {4{~stat_rd}});
         // RULE_08 overcurrent sticky, read clears
         overcurrent_flag <= overcurrent_det | (overcurrent_flag & {4{~stat_rd}});
         // RULE_11 short flags read clear
         short_circuit_flag <= short_det | (short_circuit_flag & {4{~stat_rd}});
         // RULE_13 RULE_14 condition held keeps flag
         overvoltage_flag <= overvoltage_det | (overvoltage_flag & ~stat_rd);
         // RULE_16 single undervoltage flag
         undervoltage_flag <= undervoltage_det | (undervoltage_flag & ~stat_rd);
      end
   end
   // read data, one cycle after the strobe
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0;
      end else if (reg_rd) begin
         case (reg_addr)
            A_CTRL: reg_rdata <= {23'h0, high_battery_protect_off, input_mask, on_bit};
            A_OC: reg_rdata <= {22'h0, cooling_slope_select, 1'b0, cooling_emulation_enable,
                                steady_level_select, 1'b0, inrush_step_remove, overcurrent_slope_select};
            A_STAT: reg_rdata <= {13'h0, ch_latched, ~fail_safe, undervoltage_flag, overvoltage_flag,
                                  short_circuit_flag, overcurrent_flag, overtemp_flag};
            A_RETRY: reg_rdata <= {12'h0, ch_retry};
            default: reg_rdata <= 32'h0;
         endcase
      end else begin
         reg_rdata <= 32'h0;
      end
   end
endmodule // flar_top

// ### bench/flar_checker_assertions.sv
// port checker for the fault latch and auto-retry block
`timescale 1ns/1ns
module flar_checker (
   input wire clk,
   input wire rst_n,
   input wire [3:0] overtemp_det,
   input wire [3:0] overcurrent_det,
   input wire [3:0] short_det,
   input wire overvoltage_det,
   input wire undervoltage_det,
   input wire fail_safe,
   input wire wake_reset_pin,
   input wire [3:0] output_switch,
   input wire fault_status_pin_n,
   input wire [11:0] current_level
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // overcurrent detected while channel 0 is driving
   sequence s_oc_hit; overcurrent_det[0] && output_switch[0]; endsequence
   // short on driving channel 2, held so the latch can act
   sequence s_sc_hit; (output_switch[2] && short_det[2]) ##1 short_det[2] [*2]; endsequence
   // battery overvoltage in fail-safe with the wake pin high
   sequence s_fs_ov; (fail_safe && wake_reset_pin && overvoltage_det) [*3]; endsequence
   property p_ot_off; overtemp_det[1] [*3] |-> !output_switch[1]; endproperty
   property p_ot_pin; (|overtemp_det) [*3] |-> !fault_status_pin_n; endproperty
   property p_oc_off; s_oc_hit |-> ##[1:3] !output_switch[0]; endproperty
   property p_oc_pin; s_oc_hit |-> ##[1:3] !fault_status_pin_n; endproperty
   property p_sc_off; s_sc_hit |-> !output_switch[2] && !fault_status_pin_n; endproperty
   property p_uv_off; undervoltage_det [*3] |-> output_switch == 4'h0 && !fault_status_pin_n; endproperty
   property p_fs_ov; s_fs_ov |-> output_switch == 4'h0 && !fault_status_pin_n; endproperty
   // fail-safe forces defaults: a turn-on starts at the top level
   property p_fs_inrush; fail_safe && $rose(output_switch[3]) |-> current_level[11:9] == 3'h7; endproperty
   a_ot_off: assert property (p_ot_off) else $error("overtemp output on");
   a_ot_pin: assert property (p_ot_pin) else $error("overtemp pin high");
   a_oc_off: assert property (p_oc_off) else $error("overcurrent no latch");
   a_oc_pin: assert property (p_oc_pin) else $error("overcurrent pin high");
   a_sc_off: assert property (p_sc_off) else $error("short no latch");
   a_uv_off: assert property (p_uv_off) else $error("undervoltage outputs on");
   a_fs_ov: assert property (p_fs_ov) else $error("fail-safe overvoltage missed");
   a_fs_inrush: assert property (p_fs_inrush) else $error("inrush level wrong");
endmodule // flar_checker
bind flar_top flar_checker chk_i (.clk(clk), .rst_n(rst_n), .overtemp_det(overtemp_det),
   .overcurrent_det(overcurrent_det), .short_det(short_det), .overvoltage_det(overvoltage_det),
   .undervoltage_det(undervoltage_det), .fail_safe(fail_safe), .wake_reset_pin(wake_reset_pin),
   .output_switch(output_switch), .fault_status_pin_n(fault_status_pin_n), .current_level(current_level));

// ### bench/flar_host.sv
// host controller model driving the register port
`timescale 1ns/1ns
module flar_host (
   input wire clk,
   input wire [31:0] reg_rdata,
   output reg [3:0] reg_addr,
   output reg [31:0] reg_wdata,
   output reg reg_wr,
   output reg reg_rd
);
   // idle bus at time zero
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one-cycle write; data flipped after to expose stale use
   task wr(input [3:0] a, input [31:0] d);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk);
         reg_wr <= 1'b0;
         reg_wdata <= ~d;
      end
   endtask
   // one-cycle read; data taken in the next cycle only
   task rd(input [3:0] a, output [31:0] d);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk);
         reg_rd <= 1'b0;
         @(negedge clk);
         d = reg_rdata;
      end
   endtask
endmodule // flar_host

// ### bench/fault_latch_autoretry_bench.sv
// self-checking bench for the fault latch and auto-retry block
`timescale 1ns/1ns
`include "flar_consts.vh"
module fault_latch_autoretry_bench;
   reg clk = 1'b0; // 100 MHz
   reg rst_n = 1'b0; // held for ten cycles
   reg [3:0] direct_in = 4'h0; // direct channel inputs
   reg [3:0] overtemp_det = 4'h0; // per-channel detectors
   reg [3:0] overcurrent_det = 4'h0;
   reg [3:0] short_det = 4'h0;
   reg overvoltage_det = 1'b0; // battery detectors
   reg undervoltage_det = 1'b0;
   reg logic_supply_fail = 1'b0; // supply resets
   reg supply_por = 1'b0;
   reg fail_safe = 1'b0; // mode and pins
   reg wake_reset_pin = 1'b1;
   reg modulator_en = 1'b0;
   wire [3:0] reg_addr;
   wire [31:0] reg_wdata;
   wire reg_wr;
   wire reg_rd;
   wire [31:0] reg_rdata;
   wire [3:0] output_switch;
   wire fault_status_pin_n;
   wire [11:0] current_level;
   integer num_errors = 0;
   integer tests_run = 0;
   integer n; // retries counted
   integer i;
   integer k;
   reg p; // output level one cycle back
   always #5 clk = ~clk;
   // short retry and cooling periods keep the run small
   flar_top #(.RETRY_CYC(20), .COOL_CYC(50)) dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .direct_in(direct_in),
      .overtemp_det(overtemp_det), .overcurrent_det(overcurrent_det), .short_det(short_det),
      .overvoltage_det(overvoltage_det), .undervoltage_det(undervoltage_det), .logic_supply_fail(logic_supply_fail),
      .supply_por(supply_por), .fail_safe(fail_safe), .wake_reset_pin(wake_reset_pin), .modulator_en(modulator_en),
      .output_switch(output_switch), .fault_status_pin_n(fault_status_pin_n), .current_level(current_level));
   flar_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd));
   // value compare, counted
   task chk(input logic [31:0] got, input logic [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // bounded wait for outputs and pin, then compare
   task wait_out(input [3:0] e, input f);
      integer j;
      begin
         for (j = 0; j < 60 && {fault_status_pin_n, output_switch} !== {f, e}; j = j + 1) @(negedge clk);
         chk({fault_status_pin_n, output_switch}, {f, e});
      end
   endtask
   // masked register read compare
   task rchk(input [3:0] a, input [31:0] m, input [31:0] e);
      reg [31:0] d;
      begin
         host.rd(a, d);
         chk(d & m, e);
      end
   endtask
   // idle state, defaults and an unmapped index
   task t_reset;
      begin
         chk({fault_status_pin_n, output_switch}, 5'h10);
         host.wr(4'h9, 32'h1ff);
         rchk(4'h9, 32'hffffffff, 32'h0);
         rchk(4'h0, 32'h1ff, 32'h0);
         rchk(4'h1, 32'h377, 32'h0);
         rchk(4'h2, 32'h7bfff, 32'h0);
      end
   endtask
   // overtemp on a driven channel, then on an idle one
   task t_ot;
      begin
         host.wr(4'h0, 32'h1);
         wait_out(4'h1, 1'b1);
         @(posedge clk) overtemp_det[0] <= 1'b1;
         wait_out(4'h0, 1'b0);
         repeat (3) @(posedge clk);
         overtemp_det[0] <= 1'b0;
         repeat (4) @(posedge clk);
         chk({fault_status_pin_n, output_switch}, 5'h0);
         wait_out(4'h1, 1'b1);
         rchk(4'h2, 32'h1, 32'h1);
         rchk(4'h2, 32'h1, 32'h0);
         rchk(4'h3, 32'h1f, 32'h1);
         host.wr(4'h0, 32'h0);
         @(posedge clk) overtemp_det[1] <= 1'b1;
         wait_out(4'h0, 1'b0);
         @(posedge clk) overtemp_det[1] <= 1'b0;
         wait_out(4'h0, 1'b1);
         rchk(4'h2, 32'h2, 32'h2);
      end
   endtask
   // short holds its output off once cleared; toggle and each supply reset release it
   task t_sc;
      begin
         host.wr(4'h0, 32'h4);
         wait_out(4'h4, 1'b1);
         @(posedge clk) short_det[2] <= 1'b1;
         wait_out(4'h0, 1'b0);
         @(posedge clk) short_det[2] <= 1'b0;
         repeat (100) @(posedge clk);
         chk({fault_status_pin_n, output_switch}, 5'h0);
         rchk(4'h2, 32'h400, 32'h400);
         rchk(4'h2, 32'h400, 32'h0);
         for (k = 0; k < 2; k = k + 1) begin
            host.wr(4'h0, 32'h0);
            host.wr(4'h0, 32'h4);
            wait_out(4'h4, 1'b1);
            @(posedge clk) short_det[2] <= 1'b1;
            wait_out(4'h0, 1'b0);
            @(posedge clk) short_det[2] <= 1'b0;
            rchk(4'h2, 32'h20000, 32'h20000);
            @(posedge clk) {logic_supply_fail, supply_por} <= k ? 2'b10 : 2'b01;
            repeat (3) @(posedge clk);
            {logic_supply_fail, supply_por} <= 2'b00;
            rchk(4'h2, 32'h78000, 32'h0);
         end
      end
   endtask
   // overvoltage enabled and disabled, then an undervoltage dip
   task t_ov;
      begin
         host.wr(4'h0, 32'h3);
         wait_out(4'h3, 1'b1);
         @(posedge clk) overvoltage_det <= 1'b1;
         wait_out(4'h0, 1'b0);
         @(posedge clk) overvoltage_det <= 1'b0;
         wait_out(4'h3, 1'b1);
         rchk(4'h2, 32'h1000, 32'h1000);
         rchk(4'h2, 32'h1000, 32'h0);
         host.wr(4'h0, 32'h103);
         @(posedge clk) overvoltage_det <= 1'b1;
         repeat (4) @(posedge clk);
         chk(output_switch, 4'h3);
         rchk(4'h2, 32'h1000, 32'h1000);
         rchk(4'h2, 32'h1000, 32'h1000);
         @(posedge clk) overvoltage_det <= 1'b0;
         repeat (3) @(posedge clk);
         rchk(4'h2, 32'h1000, 32'h1000);
         rchk(4'h2, 32'h1000, 32'h0);
         @(posedge clk) undervoltage_det <= 1'b1;
         wait_out(4'h0, 1'b0);
         @(posedge clk) undervoltage_det <= 1'b0;
         repeat (3) @(posedge clk);
         chk(fault_status_pin_n, 1'b0);
         wait_out(4'h3, 1'b1);
         rchk(4'h2, 32'h2000, 32'h2000);
         rchk(4'h0, 32'h1ff, 32'h103);
         host.wr(4'h0, 32'h0);
      end
   endtask
   // direct input with mask, then fail-safe overvoltage per wake pin
   task t_fs;
      begin
         @(posedge clk) modulator_en <= 1'b1;
         direct_in <= 4'h8;
         wait_out(4'h8, 1'b1);
         host.wr(4'h0, 32'h80);
         wait_out(4'h0, 1'b1);
         @(posedge clk) fail_safe <= 1'b1;
         wait_out(4'h8, 1'b1);
         @(posedge clk) overvoltage_det <= 1'b1;
         wait_out(4'h0, 1'b0);
         @(posedge clk) overvoltage_det <= 1'b0;
         wait_out(4'h8, 1'b1);
         @(posedge clk) wake_reset_pin <= 1'b0;
         overvoltage_det <= 1'b1;
         repeat (4) @(posedge clk);
         chk(output_switch, 4'h8);
         overvoltage_det <= 1'b0;
         wake_reset_pin <= 1'b1;
         fail_safe <= 1'b0;
         direct_in <= 4'h0;
      end
   endtask
   // inrush shape, steady level, retry limit and counter clearing
   task t_oc;
      begin
         host.wr(4'h1, 32'h24);
         host.wr(4'h0, 32'h1);
         wait_out(4'h1, 1'b1);
         chk(current_level[2:0], `FLAR_LVL_HI2);
         for (i = 0; i < 20000 && current_level[2:0] !== `FLAR_LVL_LO3; i = i + 1) @(negedge clk);
         chk(current_level[2:0], `FLAR_LVL_LO3);
         n = 0;
         p = 1'b1;
         for (i = 0; i < 1500; i = i + 1) begin
            @(posedge clk);
            overcurrent_det[0] <= output_switch[0];
            if (output_switch[0] && !p) begin
               n = n + 1;
               chk(current_level[2:0], `FLAR_LVL_HI1);
            end
            p = output_switch[0];
         end
         chk(n, 32'h10);
         rchk(4'h3, 32'h1f, 32'h10);
         chk({fault_status_pin_n, output_switch}, 5'h0);
         rchk(4'h2, 32'h10, 32'h10);
         host.wr(4'h0, 32'h0);
         host.wr(4'h0, 32'h1);
         wait_out(4'h1, 1'b1);
         @(posedge clk) overcurrent_det[0] <= 1'b1;
         @(posedge clk) overcurrent_det[0] <= 1'b0;
         @(negedge clk);
         wait_out(4'h1, 1'b1);
         @(posedge clk) fail_safe <= 1'b1;
         repeat (3) @(posedge clk);
         fail_safe <= 1'b0;
         rchk(4'h3, 32'h1f, 32'h0);
      end
   endtask
   // verdict and end of run
   task final_report;
      begin
         if (num_errors == 0 && tests_run > 0) begin
            $display("No errors found");
         end else begin
            $display("Errors were found");
         end
         $finish;
      end
   endtask
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      t_reset;
      t_ot;
      t_sc;
      t_ov;
      t_fs;
      t_oc;
      final_report;
   end
   // watchdog, far past the run length
   initial begin
      #1000000;
      num_errors = num_errors + 1;
      final_report;
   end
endmodule // fault_latch_autoretry_bench
